// file: core/hprc_pkg.sv
// Constants shared by the hub remap and status/command register block
package hprc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT7_MAP    = 8'hFE;  // Port seven logical map
  localparam logic [7:0] ADDR_STATUS_CMD   = 8'hFF;  // Interface status/command
  localparam logic [7:0] ADDR_PROTECT_LAST = 8'hFE;  // Top of protected range

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAP_FIELD_MSB   = 3;  // Logical number field, bits 3:0
  localparam int BIT_ATTACH      = 0;  // Attach request, write protect
  localparam int BIT_SOFT_RESET  = 1;  // Register set reset command
  localparam int BIT_POWER_DOWN  = 2;  // Serial interface power down

  // ----------------------------------------------------------------
  // Values after reset and decode limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_PORT7_MAP  = 8'h00;
  localparam logic [2:0] RESET_STATUS_CMD = 3'h0;
  localparam logic [3:0] MAP_DISABLED     = 4'h0;  // Field code for disabled
  localparam logic [3:0] MAP_LAST_VALID   = 4'h7;  // Highest legal logical number
  localparam logic [3:0] DEFAULT_LOGICAL  = 4'h7;  // Numbering without remap
  localparam logic [7:0] READ_UNDEFINED   = 8'h00;  // Answer for unmapped reads

endpackage

// file: core/hprc_map_if.sv
// Interface between the register bank and the port seven map decoder
`timescale 1ns/100ps
interface hprc_map_if;
  logic [3:0] map_field;     // Stored low nibble of the map register
  logic       mode_enable;   // Remap mode selected
  logic       port_enable;   // Port seven enabled after decode
  logic [3:0] logical_port;  // Logical number reported for port seven

  modport bank (output map_field, output mode_enable,
                input  port_enable, input logical_port);
  modport decoder (input  map_field, input mode_enable,
                   output port_enable, output logical_port);
endinterface

// file: core/hprc_remap_decode.sv
// Decoder from the port seven map field to enable and logical number
`timescale 1ns/100ps
module hprc_remap_decode (
  hprc_map_if.decoder map
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Purely combinational; the bank registers the results
  always_comb begin
    if (!map.mode_enable) begin
      // Remap off: port keeps its physical number
      map.port_enable  = 1'b1;
      map.logical_port = hprc_pkg::DEFAULT_LOGICAL;
    end else if (map.map_field == hprc_pkg::MAP_DISABLED) begin
      // Zero code turns the port off
      map.port_enable  = 1'b0;
      map.logical_port = hprc_pkg::MAP_DISABLED;
    end else if (map.map_field <= hprc_pkg::MAP_LAST_VALID) begin
      // Codes one to seven pass straight through
      map.port_enable  = 1'b1;
      map.logical_port = map.map_field;
    end else begin
      // Reserved codes act exactly like zero
      map.port_enable  = 1'b0;
      map.logical_port = hprc_pkg::MAP_DISABLED;
    end
  end

endmodule

// file: core/hprc_regs.sv
// Port seven remap register and interface status/command register
//
// Notes on behaviour
// - Map field zero disables physical port seven
// - Field one to seven gives logical number
// - Field eight to fifteen acts as disabled
// - Upper nibble reserved, never used for mapping
// - Remap applies only with remap mode enabled
// - Hub reports port count, never chooses numbers
// - Map register at FEh, cleared on reset
// - Power-down bit stops interface after acknowledge
// - Reset bit restores registers and serial interface
// - Attach bit signals attach to upstream host
// - Attach bit blocks writes to 00h-FEh
// - Attach clear keeps serial slave interface active
// - In serial load mode, present on USB only after code load; otherwise present at once
// - Undefined addresses: writes ignored, reads zero
`timescale 1ns/100ps
module hprc_regs (
  input  wire logic       CLK_SYS,              // 10 MHz system clock
  input  wire logic       RESET,                // Asynchronous, active high
  input  wire logic [7:0] REG_ADDR,             // Register address from serial engine
  input  wire logic [7:0] REG_WDATA,            // Write data
  input  wire logic       REG_WR,               // Write strobe, one cycle
  input  wire logic       REG_RD,               // Read strobe, one cycle
  input  wire logic       ACK_DONE,             // Current acknowledge finished
  input  wire logic       REMAP_MODE_ENABLE,    // Remap mode from config byte three
  input  wire logic       SMBUS_LOAD_MODE,      // Hub configured for serial load
  output logic      [7:0] REG_RDATA,            // Read answer
  output logic            PORT7_ENABLE,         // Port seven counted and usable
  output logic      [3:0] PORT7_LOGICAL,        // Logical number of port seven
  output logic            USB_ATTACH,           // Present hub upstream
  output logic            CONFIG_WRITE_PROTECT, // Lock for 00h-FEh
  output logic            SERIAL_IF_ACTIVE,     // Serial slave may run
  output logic            SERIAL_IF_RESET,      // Serial slave reset pulse
  output logic            CONFIG_RESTORE        // Other registers back to defaults
);

  // ----------------------------------------------------------------
  // Storage and next values
  // ----------------------------------------------------------------
  logic [7:0] port7_logical_map;        // Map register, upper nibble kept
  logic [7:0] next_port7_logical_map;
  logic       usb_attach_bit;           // Attach request bit
  logic       next_usb_attach_bit;
  logic       soft_reset_bit;           // Reset command, self clearing
  logic       next_soft_reset_bit;
  logic       serial_if_power_down;     // Power-down request bit
  logic       next_serial_if_power_down;
  logic       power_down_done;          // Acknowledge seen after request
  logic       next_power_down_done;
  logic [7:0] next_rdata;
  logic       wr_map;                   // Write hits map register
  logic       wr_cmd;                   // Write hits status/command

  hprc_map_if map ();

  // ----------------------------------------------------------------
  // Decoder for port seven
  // ----------------------------------------------------------------
  // Only the low nibble goes out; the upper nibble is storage only
  assign map.map_field   = port7_logical_map[hprc_pkg::MAP_FIELD_MSB:0];
  assign map.mode_enable = REMAP_MODE_ENABLE;

  hprc_remap_decode u_decode (
    .map (map.decoder)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Attach locks the whole protected range, so the map is refused
  assign wr_map = REG_WR && (REG_ADDR == hprc_pkg::ADDR_PORT7_MAP)
                  && !usb_attach_bit;
  // The command register sits above the protected range
  assign wr_cmd = REG_WR && (REG_ADDR == hprc_pkg::ADDR_STATUS_CMD);

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb begin
    next_port7_logical_map    = port7_logical_map;
    next_usb_attach_bit       = usb_attach_bit;
    next_soft_reset_bit       = 1'b0;
    next_serial_if_power_down = serial_if_power_down;
    next_power_down_done      = power_down_done;
    if (soft_reset_bit) begin
      // Command seen last cycle: restore defaults, bit falls back
      next_port7_logical_map    = hprc_pkg::RESET_PORT7_MAP;
      next_usb_attach_bit       = hprc_pkg::RESET_STATUS_CMD[hprc_pkg::BIT_ATTACH];
      next_serial_if_power_down = hprc_pkg::RESET_STATUS_CMD[hprc_pkg::BIT_POWER_DOWN];
      next_power_down_done      = 1'b0;
      next_soft_reset_bit       = 1'b0;
    end else begin
      if (wr_map) begin
        next_port7_logical_map = REG_WDATA;
      end
      if (wr_cmd) begin
        // Reserved bits 7:3 are dropped
        next_usb_attach_bit       = REG_WDATA[hprc_pkg::BIT_ATTACH];
        next_soft_reset_bit       = REG_WDATA[hprc_pkg::BIT_SOFT_RESET];
        next_serial_if_power_down = REG_WDATA[hprc_pkg::BIT_POWER_DOWN];
      end
      // Power down takes effect only once the acknowledge is over
      if (!next_serial_if_power_down) begin
        next_power_down_done = 1'b0;
      end else if (ACK_DONE) begin
        next_power_down_done = 1'b1;
      end else if (wr_cmd) begin
        // A new command waits for its own acknowledge, not a stale one
        next_power_down_done = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Answer held until the next read strobe
  always_comb begin
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      case (REG_ADDR)
        hprc_pkg::ADDR_PORT7_MAP: begin
          next_rdata = port7_logical_map;
        end
        hprc_pkg::ADDR_STATUS_CMD: begin
          next_rdata = {5'h00, serial_if_power_down, soft_reset_bit, usb_attach_bit};
        end
        default: begin
          next_rdata = hprc_pkg::READ_UNDEFINED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      port7_logical_map    <= hprc_pkg::RESET_PORT7_MAP;
      usb_attach_bit       <= 1'b0;
      soft_reset_bit       <= 1'b0;
      serial_if_power_down <= 1'b0;
      power_down_done      <= 1'b0;
      REG_RDATA            <= hprc_pkg::READ_UNDEFINED;
    end else begin
      port7_logical_map    <= next_port7_logical_map;
      usb_attach_bit       <= next_usb_attach_bit;
      soft_reset_bit       <= next_soft_reset_bit;
      serial_if_power_down <= next_serial_if_power_down;
      power_down_done      <= next_power_down_done;
      REG_RDATA            <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  // Attach, protect and active outputs follow the next state so they line up with the registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      PORT7_ENABLE         <= 1'b0;
      PORT7_LOGICAL        <= 4'h0;
      USB_ATTACH           <= 1'b0;
      CONFIG_WRITE_PROTECT <= 1'b0;
      SERIAL_IF_ACTIVE     <= 1'b1;
      SERIAL_IF_RESET      <= 1'b0;
      CONFIG_RESTORE       <= 1'b0;
    end else begin
      // Only enable counts toward the port total; host picks numbering
      PORT7_ENABLE         <= map.port_enable;
      PORT7_LOGICAL        <= map.logical_port;
      // In serial load mode the hub waits for attach, with no timeout
      USB_ATTACH           <= next_usb_attach_bit || !SMBUS_LOAD_MODE;
      CONFIG_WRITE_PROTECT <= next_usb_attach_bit;
      // Interface never powers down while attach is clear
      SERIAL_IF_ACTIVE     <= !(next_power_down_done && next_usb_attach_bit);
      SERIAL_IF_RESET      <= soft_reset_bit;
      CONFIG_RESTORE       <= soft_reset_bit;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_map_zero_off: assert property (
    (REMAP_MODE_ENABLE && port7_logical_map[3:0] == 4'h0) |=> !PORT7_ENABLE)
    else $error("Zero map code left port on");
  a_map_pass_num: assert property (
    (REMAP_MODE_ENABLE && port7_logical_map[3:0] inside {[4'h1:4'h7]})
    |=> (PORT7_ENABLE && PORT7_LOGICAL == $past(port7_logical_map[3:0])))
    else $error("Legal map code not reported");
  a_map_resv_off: assert property (
    (REMAP_MODE_ENABLE && port7_logical_map[3])
    |=> (!PORT7_ENABLE && PORT7_LOGICAL == 4'h0))
    else $error("Reserved code enabled port");
  a_map_default: assert property (
    !REMAP_MODE_ENABLE |=> (PORT7_ENABLE && PORT7_LOGICAL == 4'h7))
    else $error("Default numbering not used");
  // A pending soft reset restores the map even while protected
  a_protect_map: assert property (
    (usb_attach_bit && !soft_reset_bit && REG_WR && REG_ADDR == 8'hFE)
    |=> $stable(port7_logical_map)) else $error("Map written while protected");
  a_soft_reset: assert property (
    soft_reset_bit |=> (!soft_reset_bit && port7_logical_map == 8'h00
    && !usb_attach_bit && SERIAL_IF_RESET)) else $error("Soft reset did not restore");
  a_rst_selfclr: assert property (
    (wr_cmd && REG_WDATA[1] && !soft_reset_bit) |=> soft_reset_bit ##1 !soft_reset_bit)
    else $error("Reset bit not self clearing");
  a_pd_after_ack: assert property (
    (serial_if_power_down && usb_attach_bit && !power_down_done && !ACK_DONE)
    |=> SERIAL_IF_ACTIVE) else $error("Powered down before acknowledge");
  a_pd_on_ack: assert property (
    (serial_if_power_down && usb_attach_bit && ACK_DONE && !wr_cmd && !soft_reset_bit)
    |=> !SERIAL_IF_ACTIVE) else $error("No power down after acknowledge");
  a_active_detach: assert property (
    !usb_attach_bit |-> SERIAL_IF_ACTIVE) else $error("Interface off while detached");
  a_undef_read: assert property (
    (REG_RD && REG_ADDR < 8'hFE) |=> REG_RDATA == 8'h00)
    else $error("Undefined read not zero");
  a_attach_out: assert property (
    (SMBUS_LOAD_MODE && !next_usb_attach_bit) |=> !USB_ATTACH)
    else $error("Attached before code load");

  c_remap_used: cover property (REMAP_MODE_ENABLE && wr_map ##1 PORT7_ENABLE);
  c_attach_seq: cover property (wr_cmd && REG_WDATA[0] ##1 USB_ATTACH);
  c_soft_reset: cover property (soft_reset_bit ##1 CONFIG_RESTORE);
  c_power_down: cover property (SERIAL_IF_ACTIVE ##1 !SERIAL_IF_ACTIVE);

endmodule

// file: verif/hprc_host_model.sv
// Host stand-in that issues single-byte register cycles to the bank
`timescale 1ns/100ps
module hprc_host_model (
  input  wire logic       CLK_SYS,   // System clock
  output logic      [7:0] REG_ADDR,  // Register address
  output logic      [7:0] REG_WDATA, // Write data
  output logic            REG_WR,    // Write strobe
  output logic            REG_RD,    // Read strobe
  output logic            ACK_DONE   // Acknowledge finished pulse
);
  // ------------------------------------------------------------
  // Idle state at time zero
  // ------------------------------------------------------------
  initial begin
    REG_ADDR  = 8'h5A;
    REG_WDATA = 8'hA5;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    ACK_DONE  = 1'b0;
  end

  // One strobe cycle; idle lines show the inverse so stale values never look valid
  task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge CLK_SYS);
    #1;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = w;
    REG_RD    = ~w;
    @(posedge CLK_SYS);
    #1;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = ~a;
    REG_WDATA = ~d;
  endtask

  // Acknowledge pulse from the serial engine, one cycle wide
  task automatic ack();
    @(posedge CLK_SYS);
    #1;
    ACK_DONE = 1'b1;
    @(posedge CLK_SYS);
    #1;
    ACK_DONE = 1'b0;
  endtask
endmodule

// file: verif/hprc_regs_tb_top.sv
// Self-checking bench for the port seven map and status/command registers
`timescale 1ns/100ps
module hprc_regs_tb_top;
  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  logic       clk_sys = 1'b0;  // 10 MHz clock
  logic       reset   = 1'b1;  // Held for ten cycles
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lf;
  logic       reg_wr, reg_rd, ack_done, rd_d = 1'b0;
  logic       mode = 1'b1, load = 1'b1;
  logic       en, rst_p, rest_p, att, prot, act;
  logic [3:0] lg;
  logic [7:0] exp_q[$];        // Expected read answers, oldest first
  int         bad_count = 0;
  int         n_tests   = 0;

  always #50 clk_sys = ~clk_sys;

  hprc_host_model u_hprc_host_model (.CLK_SYS(clk_sys), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .ACK_DONE(ack_done));

  hprc_regs u_hprc_regs (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .ACK_DONE(ack_done),
    .REMAP_MODE_ENABLE(mode), .SMBUS_LOAD_MODE(load), .REG_RDATA(reg_rdata),
    .PORT7_ENABLE(en), .PORT7_LOGICAL(lg), .USB_ATTACH(att),
    .CONFIG_WRITE_PROTECT(prot), .SERIAL_IF_ACTIVE(act),
    .SERIAL_IF_RESET(rst_p), .CONFIG_RESTORE(rest_p));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_hprc_host_model.cyc(a, d, 1'b1);
  endtask

  // Reads note their expectation before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    u_hprc_host_model.cyc(a, 8'h00, 1'b0);
  endtask

  task automatic settle();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Read monitor: each answer is compared against the oldest note
  // ------------------------------------------------------------
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[ERR] %0t read answer with no note", $time);
      end else begin
        check(reg_rdata, exp_q.pop_front());
      end
    end
  end

  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int sr, cr;
    logic [7:0] v;
    lf = 8'h1D;
    repeat (10) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    rd(8'hFE, 8'h00);
    rd(8'hFF, 8'h00);
    check(act, 1'b1);
    check(att, 1'b0);
    // Every map code with remap off, then on; random upper nibble never matters
    // Remap stays on afterwards for the later numbering check
    for (int m = 0; m <= 1; m++) begin
      for (int i = 0; i < 16; i++) begin
        lf = lfsr(lf);
        v = {lf[7:4], 4'(i)};
        mode = m[0];
        wr(8'hFE, v);
        settle();
        if (m == 0) begin
          check(en, 1'b1);
          check(lg, 4'h7);
        end else begin
          check(en, (i >= 1 && i <= 7));
          check(lg, (i >= 1 && i <= 7) ? 4'(i) : 4'h0);
        end
        rd(8'hFE, v);
      end
    end
    // Unmapped address: write dropped, read gives zero
    wr(8'h10, lf);
    rd(8'h10, 8'h00);
    rd(8'hFE, v);
    // Power-down bit alone keeps the interface up while attach is clear
    wr(8'hFF, 8'h04);
    u_hprc_host_model.ack();
    settle();
    check(act, 1'b1);
    // Attach locks the map register, then power-down takes effect after ack
    wr(8'hFF, 8'h05);
    settle();
    check(att, 1'b1);
    check(prot, 1'b1);
    wr(8'hFE, 8'h03);
    rd(8'hFE, v);
    rd(8'hFF, 8'h05);
    check(act, 1'b1);
    u_hprc_host_model.ack();
    settle();
    check(act, 1'b0);
    // Soft reset: one pulse of each, then defaults and self-clearing bit
    wr(8'hFF, 8'h02);
    sr = 0;
    cr = 0;
    for (int k = 0; k < 4; k++) begin
      sr += (rst_p === 1'b1);
      cr += (rest_p === 1'b1);
      settle();
    end
    check(sr, 1);
    check(cr, 1);
    check(att, 1'b0);
    check(act, 1'b1);
    rd(8'hFE, 8'h00);
    rd(8'hFF, 8'h00);
    // Contiguous numbering from one for the single owned port
    wr(8'hFE, 8'h01);
    settle();
    check(lg, 4'h1);
    // Without serial load the hub presents itself at once
    @(posedge clk_sys);
    #1;
    load = 1'b0;
    settle();
    settle();
    check(att, 1'b1);
    settle();
    summarize();
  end
endmodule
